/* design/prdl_pkg.sv */
// Purpose: constants, codewords and types for the primary-rate data link messaging block.
// Assumes: 125 MHz clock; codeword low bytes are kept as printed, leftmost bit sent first.
// Notes: times are kept in their own units and converted to cycles here.
// Operation
// - Send a priority codeword repeatedly, unbroken, while its trigger condition lasts.
// - Priority repetition may pause at most 100 ms, at most once per second; the pause re-arms at every second tick, so two can run back to back.
// - On local frame alignment loss send remote alarm codeword, at least one second.
// - Send loopback retention codeword continuously while the loop needs sustaining.
// - A line loopback returns the whole received signal, framing bits included.
// - Four line loopback operate codes, one own release, one shared universal release.
// - Payload loopback returns information bits only; framing bits are regenerated locally.
// - Payload loopback has own operate and release codes and obeys universal release.
// - Protection operate codeword carries line number, LSB sent first, lines 1 to 27.
// - Protection switching also has a release codeword and an acknowledge codeword.
// - Ten synchronization status codewords exist; a network may use a subset.
// - Count tracked events per contiguous second; send a report once each second.
// - A report frame is 15 bytes including both flags.
// - The information field is eight octets covering the four latest seconds.
// - Each second advance a modulo 4 counter and fill octets 5 and 6.
// - Older octet pairs shift down two places; the oldest pair is dropped.
// - The report uses SAPI 14.
// - C/R is 1 inside the network, 0 in a customer installation.
// - TEI is zero; EA is 0 with the SAPI and 1 with the TEI.
// - Track check bit errors, alignment errors, bipolar violations, slips, payload loop.
// - Two or more alignment errors in one 3 ms window flag a severe event.
// - Every report octet is sent rightmost bit first.
// - The data link uses the first bit of odd frames from frame 1.
// - Codewords are 16 bits: ones, a zero, six message bits, a zero.
// - With nothing pending the link carries the flag pattern 01111110 repeatedly.
// - Starting any codeword aborts a performance report in progress.
package prdl_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned SEC_MS = 1000;
    localparam int unsigned PAUSE_MS = 100;
    localparam int unsigned GUARD_US = 4000;
    localparam int unsigned SEFW_US = 3000;
    localparam int unsigned SEC_CYC = SEC_MS * 1000 * CLK_MHZ;
    localparam int unsigned PAUSE_CYC = (PAUSE_MS * 1000 - GUARD_US) * CLK_MHZ;
    localparam int unsigned SEFW_CYC = SEFW_US * CLK_MHZ;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_MSG = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_HIST0 = 8'h0C;
    localparam logic [7:0] A_HIST1 = 8'h10;
    localparam int C_RET = 0;
    localparam int C_NET = 1;
    localparam int C_MSG = 2;
    localparam int C_RPT = 3;
    localparam int LOOP_N = 4;
    localparam int LB_CIA = 0;
    localparam int LB_CIB = 1;
    localparam int LB_CIC = 2;
    localparam int LB_NA = 3;
    localparam logic [7:0] CW_ONES = 8'hFF;
    localparam logic [7:0] M_RAI = 8'h00;
    localparam logic [7:0] M_RET = 8'h54;
    localparam logic [7:0] M_CIA_OP = 8'h70;
    localparam logic [7:0] M_CIA_REL = 8'h1C;
    localparam logic [7:0] M_CIB_OP = 8'h04;
    localparam logic [7:0] M_CIC_OP = 8'h74;
    localparam logic [7:0] M_PL_OP = 8'h28;
    localparam logic [7:0] M_PL_REL = 8'h4C;
    localparam logic [7:0] M_NA_OP = 8'h48;
    localparam logic [7:0] M_UNIV = 8'h24;
    localparam logic [7:0] M_PS_ACK = 8'h18;
    localparam logic [7:0] M_PS_REL = 8'h64;
    localparam logic [7:0] M_PS_MASK = 8'h83;
    localparam logic [7:0] M_PS_TAG = 8'h02;
    localparam logic [4:0] PS_LINES = 5'h1B;
    localparam logic [7:0] SSM_CODES [10] = '{8'h20, 8'h30, 8'h3E, 8'h08, 8'h14,
                                              8'h44, 8'h1E, 8'h10, 8'h0C, 8'h02};
    localparam logic [7:0] FLAG = 8'h7E;
    localparam logic [7:0] UI_CTRL = 8'h03;
    localparam logic [5:0] SAPI = 6'h0E;
    localparam logic [6:0] TEI = 7'h00;
    localparam logic [3:0] IDX_SAPI = 4'h1;
    localparam logic [3:0] IDX_TEI = 4'h2;
    localparam logic [3:0] IDX_CTL = 4'h3;
    localparam logic [3:0] INFO0 = 4'h4;
    localparam logic [3:0] INFO_LAST = 4'hB;
    localparam logic [3:0] FCS_LO = 4'hC;
    localparam logic [3:0] FCS_HI = 4'hD;
    localparam logic [3:0] RPT_LAST = 4'hE;
    localparam logic [15:0] FCS_INIT = 16'hFFFF;
    localparam logic [15:0] FCS_POLY = 16'h8408;
    localparam logic [2:0] MAX_ONES = 3'h5;
    localparam logic [2:0] CRC_SAT = 3'h7;
    typedef enum logic [2:0] {
        TX_FLAG = 3'b001,
        TX_CODE = 3'b010,
        TX_RPT = 3'b100
    } prdl_tx_t;
endpackage : prdl_pkg

/* design/prdl_top.sv */
// Purpose: data link messaging for a 1544 kbit/s extended multiframe terminal.
// Assumes: framer logic on clk supplies F-bit ticks, events and loss of alignment.
// Notes: loopback outputs steer the framer datapath; this block only decides them.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module prdl_top #(
    parameter int unsigned SEC_CYCLES = prdl_pkg::SEC_CYC,
    parameter int unsigned PAUSE_CYCLES = prdl_pkg::PAUSE_CYC,
    parameter int unsigned SEFW_CYCLES = prdl_pkg::SEFW_CYC
) (
    input logic clk,
    input logic rst_n,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input logic tx_fbit_tick,
    input logic tx_mf_first,
    output logic dl_tx_bit,
    input logic rx_fbit_tick,
    input logic rx_mf_first,
    input logic rx_fbit,
    input logic frame_alignment_loss,
    input logic crc_err,
    input logic mf_err,
    input logic bpv,
    input logic slip,
    output logic [prdl_pkg::LOOP_N-1:0] line_loop,
    output logic payload_loop
);
    import prdl_pkg::*;

    // ==========
    // Data link slots and timebases
    logic tx_odd;
    logic rx_odd;
    logic tx_slot;
    logic rx_slot;
    logic [31:0] sec_cnt;
    logic sec_tick;
    logic [31:0] win_cnt;
    logic win_end;
    logic win_err;
    logic sef_hit;

    assign tx_slot = tx_fbit_tick & (tx_mf_first | tx_odd);
    assign rx_slot = rx_fbit_tick & (rx_mf_first | rx_odd);
    assign sec_tick = (sec_cnt == SEC_CYCLES - 1);
    assign win_end = (win_cnt == SEFW_CYCLES - 1);
    assign sef_hit = mf_err & win_err;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_odd <= 1'h0;
            rx_odd <= 1'h0;
        end else begin
            if (tx_fbit_tick) begin
                tx_odd <= tx_mf_first ? 1'h0 : ~tx_odd;
            end
            if (rx_fbit_tick) begin
                rx_odd <= rx_mf_first ? 1'h0 : ~rx_odd;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || sec_tick) begin
            sec_cnt <= 32'h0;
        end else begin
            sec_cnt <= sec_cnt + 32'h1;
        end
    end

    // Windows run back to back; an error in the closing cycle still pairs with that window.
    always_ff @(posedge clk) begin
        if (!rst_n || win_end) begin
            win_cnt <= 32'h0;
            win_err <= 1'h0;
        end else begin
            win_cnt <= win_cnt + 32'h1;
            if (mf_err) begin
                win_err <= 1'h1;
            end
        end
    end

    // ==========
    // Per-second event collection and report history
    logic [2:0] crc_n;
    logic [2:0] crc_new;
    logic fe_s;
    logic se_s;
    logic lv_s;
    logic sl_s;
    logic lb_s;
    logic [7:0] oct_a;
    logic [7:0] info [8];
    logic [1:0] mod4;

    assign crc_new = (crc_err && crc_n != CRC_SAT) ? 3'(crc_n + 3'h1) : crc_n;
    // Tick-cycle events count for the closing second.
    assign oct_a = {lb_s | payload_loop, sl_s | slip, lv_s | bpv, se_s | sef_hit,
                    fe_s | mf_err, crc_new};

    always_ff @(posedge clk) begin
        if (!rst_n || sec_tick) begin
            crc_n <= 3'h0;
            fe_s <= 1'h0;
            se_s <= 1'h0;
            lv_s <= 1'h0;
            sl_s <= 1'h0;
            lb_s <= 1'h0;
        end else begin
            crc_n <= crc_new;
            fe_s <= fe_s | mf_err;
            se_s <= se_s | sef_hit;
            lv_s <= lv_s | bpv;
            sl_s <= sl_s | slip;
            lb_s <= lb_s | payload_loop;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mod4 <= 2'h0;
            for (int i = 0; i < 8; i++) begin
                info[i] <= 8'h00;
            end
        end else if (sec_tick) begin
            mod4 <= 2'(mod4 + 2'h1);
            info[0] <= oct_a;
            info[1] <= {6'h00, 2'(mod4 + 2'h1)};
            for (int i = 2; i < 8; i++) begin
                info[i] <= info[i-2];
            end
        end
    end

    // ==========
    // Register file
    logic [3:0] ctrl;
    logic [7:0] msg_raw;
    logic [4:0] msg_ln;
    logic msg_lm;
    logic acc;
    logic wr_q;
    logic [7:0] wa_q;
    logic [31:0] rd_val;
    logic paused;
    logic rai_on;
    logic rpt_busy;
    logic [7:0] rx_msg;
    logic [4:0] rx_line;
    logic rx_ssm;

    assign acc = hsel & hready & htrans[1];
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= 1'h0;
            wa_q <= 8'h00;
        end else begin
            wr_q <= acc & hwrite;
            wa_q <= haddr[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= 4'h0;
            msg_raw <= 8'h00;
            msg_ln <= 5'h00;
            msg_lm <= 1'h0;
        end else if (wr_q) begin
            case (wa_q)
                A_CTRL: ctrl <= hwdata[3:0];
                A_MSG: begin
                    msg_raw <= hwdata[7:0];
                    msg_ln <= hwdata[12:8];
                    msg_lm <= hwdata[13];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        case (haddr[7:0])
            A_CTRL: rd_val = {28'h0, ctrl};
            A_MSG: rd_val = {18'h0, msg_lm, msg_ln, msg_raw};
            A_STAT: rd_val = {10'h0, rx_ssm, rx_line, rx_msg, rpt_busy, paused,
                              payload_loop, line_loop, rai_on};
            A_HIST0: rd_val = {info[3], info[2], info[1], info[0]};
            A_HIST1: rd_val = {info[7], info[6], info[5], info[4]};
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0;
        end else if (acc && !hwrite) begin
            hrdata <= rd_val;
        end
    end

    // ==========
    // Codeword selection
    logic loss_q;
    logic [31:0] rai_cnt;
    logic prio_on;
    logic pause_used;
    logic [31:0] pause_cnt;
    logic code_req;
    logic [7:0] code_sel;
    logic [7:0] msg_byte;

    assign rai_on = frame_alignment_loss | (rai_cnt != 32'h0);
    assign prio_on = rai_on | ctrl[C_RET];
    assign msg_byte = msg_lm ? {1'h0, msg_ln[0], msg_ln[1], msg_ln[2], msg_ln[3], msg_ln[4],
                                M_PS_TAG[1:0]} : msg_raw;

    // Counting from onset makes even a brief loss alarm for one second.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loss_q <= 1'h0;
            rai_cnt <= 32'h0;
        end else begin
            loss_q <= frame_alignment_loss;
            if (frame_alignment_loss && !loss_q) begin
                rai_cnt <= SEC_CYCLES - 1;
            end else if (rai_cnt != 32'h0) begin
                rai_cnt <= rai_cnt - 32'h1;
            end
        end
    end

    // The pause window is shortened by one codeword time, since the codeword in flight finishes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            paused <= 1'h0;
            pause_used <= 1'h0;
            pause_cnt <= 32'h0;
        end else begin
            if (sec_tick) begin
                pause_used <= 1'h0;
            end
            if (paused) begin
                pause_cnt <= pause_cnt + 32'h1;
                if (pause_cnt == PAUSE_CYCLES - 1 || !ctrl[C_MSG]) begin
                    paused <= 1'h0;
                end
            end else if (prio_on && ctrl[C_MSG] && !pause_used) begin
                paused <= 1'h1;
                pause_used <= 1'h1;
                pause_cnt <= 32'h0;
            end
        end
    end

    always_comb begin
        code_req = 1'h1;
        if (rai_on && !paused) begin
            code_sel = M_RAI;
        end else if (ctrl[C_RET] && !paused) begin
            code_sel = M_RET;
        end else if (ctrl[C_MSG]) begin
            code_sel = msg_byte;
        end else begin
            code_req = 1'h0;
            code_sel = M_RAI;
        end
    end

    // ==========
    // Transmitter
    prdl_tx_t st;
    logic [7:0] sh;
    logic [15:0] cw;
    logic [3:0] bitn;
    logic [3:0] idx;
    logic [3:0] idx_n;
    logic [2:0] ones;
    logic [15:0] crc;
    logic [15:0] crc_nx;
    logic [7:0] fcs_hi;
    logic [7:0] rb;
    logic rpt_pend;
    logic rpt_start;
    logic stuff_zone;

    assign idx_n = idx + 4'h1;
    assign rpt_busy = (st == TX_RPT);
    assign rpt_start = tx_slot && st == TX_FLAG && bitn == 4'h7 && !code_req && rpt_pend;
    // Stuffing also covers the slot just before the closing flag.
    assign stuff_zone = (idx != 4'h0) && (idx != RPT_LAST || bitn == 4'h0);
    assign crc_nx = {1'h0, crc[15:1]} ^ ((crc[0] ^ sh[0]) ? FCS_POLY : 16'h0);

    always_comb begin
        case (idx_n)
            IDX_SAPI: rb = {SAPI, ctrl[C_NET], 1'h0};
            IDX_TEI: rb = {TEI, 1'h1};
            IDX_CTL: rb = UI_CTRL;
            FCS_LO: rb = ~crc_nx[7:0];
            FCS_HI: rb = fcs_hi;
            RPT_LAST: rb = FLAG;
            default: begin
                rb = FLAG;
                if (idx_n >= INFO0 && idx_n <= INFO_LAST) begin
                    rb = info[3'(idx_n - INFO0)];
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rpt_pend <= 1'h0;
        end else if (sec_tick && ctrl[C_RPT]) begin
            rpt_pend <= 1'h1;
        end else if (rpt_start) begin
            rpt_pend <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= TX_FLAG;
            sh <= FLAG;
            cw <= 16'h0;
            bitn <= 4'h0;
            idx <= 4'h0;
            ones <= 3'h0;
            crc <= FCS_INIT;
            fcs_hi <= 8'h00;
            dl_tx_bit <= 1'h0;
        end else if (tx_slot) begin
            case (st)
                TX_FLAG: begin
                    dl_tx_bit <= sh[0];
                    sh <= {1'h0, sh[7:1]};
                    bitn <= 4'(bitn + 4'h1);
                    if (bitn == 4'h7) begin
                        bitn <= 4'h0;
                        sh <= FLAG;
                        if (code_req) begin
                            st <= TX_CODE;
                            cw <= {CW_ONES, code_sel};
                        end else if (rpt_start) begin
                            st <= TX_RPT;
                            idx <= 4'h0;
                            ones <= 3'h0;
                            crc <= FCS_INIT;
                        end
                    end
                end
                TX_CODE: begin
                    dl_tx_bit <= cw[15];
                    cw <= {cw[14:0], 1'h0};
                    bitn <= 4'(bitn + 4'h1);
                    if (bitn == 4'hF) begin
                        bitn <= 4'h0;
                        if (code_req) begin
                            cw <= {CW_ONES, code_sel};
                        end else begin
                            st <= TX_FLAG;
                            sh <= FLAG;
                        end
                    end
                end
                TX_RPT: begin
                    if (code_req) begin
                        // The codeword's ones double as the abort.
                        st <= TX_CODE;
                        dl_tx_bit <= CW_ONES[7];
                        cw <= {CW_ONES[6:0], code_sel, 1'h0};
                        bitn <= 4'h1;
                        idx <= 4'h0;
                    end else if (stuff_zone && ones == MAX_ONES) begin
                        dl_tx_bit <= 1'h0;
                        ones <= 3'h0;
                    end else begin
                        dl_tx_bit <= sh[0];
                        sh <= {1'h0, sh[7:1]};
                        ones <= sh[0] ? 3'(ones + 3'h1) : 3'h0;
                        if (idx >= IDX_SAPI && idx <= INFO_LAST) begin
                            crc <= crc_nx;
                        end
                        bitn <= 4'(bitn + 4'h1);
                        if (bitn == 4'h7) begin
                            bitn <= 4'h0;
                            if (idx == RPT_LAST) begin
                                st <= TX_FLAG;
                                sh <= FLAG;
                                idx <= 4'h0;
                            end else begin
                                idx <= idx_n;
                                sh <= rb;
                                if (idx == INFO_LAST) begin
                                    fcs_hi <= ~crc_nx[15:8];
                                end
                            end
                        end
                    end
                end
                default: begin
                    st <= TX_FLAG;
                    sh <= FLAG;
                    bitn <= 4'h0;
                end
            endcase
        end
    end

    // ==========
    // Receiver and loopback control
    logic [15:0] rx_sh;
    logic [15:0] rx_nx;
    logic rx_hit;
    logic [4:0] ps_line;
    logic ps_ok;
    logic ssm_hit;

    assign rx_nx = {rx_sh[14:0], rx_fbit};
    assign rx_hit = rx_slot && rx_nx[15:8] == CW_ONES && !rx_nx[7] && !rx_nx[0];
    assign ps_line = {rx_nx[2], rx_nx[3], rx_nx[4], rx_nx[5], rx_nx[6]};
    assign ps_ok = ((rx_nx[7:0] & M_PS_MASK) == M_PS_TAG) && ps_line != 5'h00
                   && ps_line <= PS_LINES;

    always_comb begin
        ssm_hit = 1'h0;
        for (int i = 0; i < 10; i++) begin
            if (rx_nx[7:0] == SSM_CODES[i]) begin
                ssm_hit = 1'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_sh <= 16'h0;
        end else if (rx_slot) begin
            rx_sh <= rx_nx;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_loop <= '0;
            payload_loop <= 1'h0;
            rx_msg <= 8'h00;
            rx_line <= 5'h00;
            rx_ssm <= 1'h0;
        end else if (rx_hit) begin
            rx_msg <= rx_nx[7:0];
            rx_line <= ps_ok ? ps_line : 5'h00;
            rx_ssm <= ssm_hit;
            case (rx_nx[7:0])
                M_CIA_OP: line_loop[LB_CIA] <= 1'h1;
                M_CIB_OP: line_loop[LB_CIB] <= 1'h1;
                M_CIC_OP: line_loop[LB_CIC] <= 1'h1;
                M_NA_OP: line_loop[LB_NA] <= 1'h1;
                M_CIA_REL: line_loop[LB_CIA] <= 1'h0;
                M_PL_OP: payload_loop <= 1'h1;
                M_PL_REL: payload_loop <= 1'h0;
                M_UNIV: begin
                    line_loop <= '0;
                    payload_loop <= 1'h0;
                end
                default: ;
            endcase
        end
    end
endmodule : prdl_top

/* bench/prdl_far.sv */
// Purpose: far-end terminal model facing prdl_top.
// Assumes: one F-bit tick every 4 clocks, 24-frame multiframe.
// Notes: sends idle flags unless send is high.
`timescale 1ns/1ps
// ==========
// Far end
module prdl_far (
    input logic clk,
    input logic rst_n,
    input logic send,
    input logic [15:0] cw,
    output logic tick,
    output logic mf,
    output logic fbit
);
    logic [1:0] cnt;
    logic [4:0] fr;
    logic [3:0] bc;
    logic [15:0] sh;
    logic [15:0] word;
    // A new unit starts only on a 16-bit boundary, so no codeword is cut short.
    assign word = (bc == 4'h0) ? (send ? cw : 16'h7E7E) : sh;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {cnt, fr, bc, tick, mf, fbit} <= '0;
            sh <= 16'h7E7E;
        end else begin
            cnt <= cnt + 2'h1;
            tick <= (cnt == 2'h2);
            mf <= (cnt == 2'h2) && (fr == 5'h00);
            if (cnt == 2'h3) fr <= (fr == 5'h17) ? 5'h00 : fr + 5'h01;
            if (cnt == 2'h0 && !fr[0]) begin
                fbit <= word[15];
                sh <= {word[14:0], word[15]};
                bc <= bc + 4'h1;
            end else if (cnt == 2'h0) begin
                // Framing bits keep moving so a stale link bit is never reused.
                fbit <= ~fbit;
            end
        end
    end
endmodule : prdl_far

/* bench/prdl_chk_asserts.sv */
// Purpose: port checks for prdl_top.
// Assumes: codewords arrive leftmost bit first in odd frames.
// Notes: a shadow shift rebuilds the received codeword.
`timescale 1ns/1ps
// ==========
// Checker
module prdl_chk
    import prdl_pkg::*;
(
    input logic clk,
    input logic rst_n,
    input logic hreadyout,
    input logic hresp,
    input logic tx_fbit_tick,
    input logic dl_tx_bit,
    input logic rx_fbit_tick,
    input logic rx_mf_first,
    input logic rx_fbit,
    input logic [prdl_pkg::LOOP_N-1:0] line_loop,
    input logic payload_loop
);
    logic odd;
    logic [15:0] sh;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            odd <= 1'b0;
            sh <= 16'h0000;
        end else if (rx_fbit_tick) begin
            odd <= ~(rx_mf_first | odd);
            if (rx_mf_first | odd) sh <= {sh[14:0], rx_fbit};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ok; hreadyout && !hresp; endproperty
    a_ok: assert property (p_ok) else $error("bus answer not ready");
    property p_slot; $changed(dl_tx_bit) |-> $past(tx_fbit_tick); endproperty
    a_slot: assert property (p_slot) else $error("link bit off slot");
    property p_univ; sh == {CW_ONES, M_UNIV} |-> ##[1:4] (line_loop == '0 && !payload_loop);
    endproperty
    a_univ: assert property (p_univ) else $error("loops not released");
    property p_cia; sh == {CW_ONES, M_CIA_OP} |-> ##[1:4] line_loop[LB_CIA]; endproperty
    a_cia: assert property (p_cia) else $error("loop A not set");
    property p_cib; sh == {CW_ONES, M_CIB_OP} |-> ##[1:4] line_loop[LB_CIB]; endproperty
    a_cib: assert property (p_cib) else $error("loop B not set");
    property p_rel; sh == {CW_ONES, M_CIA_REL} |-> ##[1:4] !line_loop[LB_CIA]; endproperty
    a_rel: assert property (p_rel) else $error("loop A kept");
    property p_pl; sh == {CW_ONES, M_PL_OP} |-> ##[1:4] payload_loop[*4]; endproperty
    a_pl: assert property (p_pl) else $error("payload loop not set");
    property p_plr; sh == {CW_ONES, M_PL_REL} |-> ##[1:4] !payload_loop; endproperty
    a_plr: assert property (p_plr) else $error("payload loop kept");
endmodule : prdl_chk
bind prdl_top prdl_chk u_chk (.*);

/* bench/prdl_bench.sv */
// Purpose: self-checking bench for prdl_top.
// Assumes: short second of 2000 clocks.
// Notes: link bits are captured at odd-frame slots.
`timescale 1ns/1ps
// ==========
// Bench
module prdl_bench;
    import prdl_pkg::*;
    localparam int SEC = 2000;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, send = 0, fal = 0, found, odd = 0;
    logic crc = 0, mfe = 0, bpv = 0, slip = 0, tick, mf, fb, dl, hrdy, pl;
    logic [1:0] htrans = 0;
    logic [3:0] ll;
    logic [15:0] cw = 0, mw = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, h, lw = 0;
    logic [15:0] msgs [4] = '{16'h0018, 16'h3B00, 16'h0000, 16'h0064};
    logic [7:0] exps [4] = '{8'h18, 8'h6E, 8'h54, 8'h64};
    logic [7:0] ops [4] = '{M_CIA_OP, M_CIB_OP, M_CIC_OP, M_NA_OP};
    int n_errors = 0, total_checks = 0;
    initial forever #4 clk = ~clk;
    prdl_far far (.clk(clk), .rst_n(rst_n), .send(send), .cw(cw), .tick(tick), .mf(mf),
        .fbit(fb));
    prdl_top #(.SEC_CYCLES(SEC), .PAUSE_CYCLES(200), .SEFW_CYCLES(50)) dut (.clk(clk),
        .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(),
        .hrdata(hrdata), .tx_fbit_tick(tick), .tx_mf_first(mf), .dl_tx_bit(dl),
        .rx_fbit_tick(tick), .rx_mf_first(mf), .rx_fbit(fb), .frame_alignment_loss(fal),
        .crc_err(crc), .mf_err(mfe), .bpv(bpv), .slip(slip), .line_loop(ll), .payload_loop(pl));
    always @(posedge clk) if (tick) begin
        odd <= ~(mf | odd);
        if (mf | odd) begin
            lw <= {dl, lw[31:1]};
            mw <= {mw[14:0], dl};
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        {hsel, htrans, hwdata} <= {3'h0, d};
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic seek(input logic m, input logic [31:0] p, input int lim);
        found = 0;
        for (int i = 0; i < lim && !found; i++) begin
            @(posedge clk);
            #1 found = m ? (mw === p[15:0]) : (lw === p);
        end
    endtask : seek
    task automatic rx(input logic [7:0] b);
        cw <= {8'hFF, b};
        send <= 1;
        repeat (400) @(posedge clk);
    endtask : rx
    task automatic sec(output logic [31:0] v);
        bus(0, A_HIST0, 0);
        v = rd;
        for (int i = 0; i < SEC && rd[15:8] === v[15:8]; i++) bus(0, A_HIST0, 0);
        v = rd;
    endtask : sec
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        bus(1, A_MSG, 32'h3B18);
        bus(0, A_MSG, 0);
        chk(rd, 32'h3B18);
        bus(0, 8'h14, 0);
        chk(rd, 0);
        seek(0, 32'h7E7E7E7E, 400);
        chk(found, 1);
        bus(1, A_CTRL, 32'hA);
        seek(0, 32'h03013A7E, 3 * SEC);
        chk(found, 1);
        for (int i = 0; i < 4; i++) begin
            bus(1, A_MSG, msgs[i]);
            bus(1, A_CTRL, {29'h0, msgs[i] == 0, 2'h0} ^ 32'h5);
            seek(1, {16'h0, 8'hFF, exps[i]}, 3 * SEC);
            chk(found, 1);
        end
        bus(1, A_CTRL, 0);
        fal <= 1;
        seek(1, 32'hFF00, 800);
        chk(found, 1);
        fal <= 0;
        repeat (SEC / 2) @(posedge clk);
        seek(1, 32'hFF00, 300);
        chk(found, 1);
        repeat (SEC) @(posedge clk);
        bus(0, A_STAT, 0);
        chk(rd[0], 0);
        for (int i = 0; i < 4; i++) begin
            rx(ops[i]);
            chk(ll, 4'h1 << i);
            rx(M_UNIV);
            chk(ll, 0);
        end
        rx(M_CIA_OP);
        rx(M_CIA_REL);
        chk(ll, 0);
        rx(M_PL_OP);
        chk(pl, 1);
        rx(M_PL_REL);
        chk(pl, 0);
        rx(M_PL_OP);
        rx(M_UNIV);
        chk(pl, 0);
        rx(8'h6E);
        bus(0, A_STAT, 0);
        chk(rd[21:16], 6'h1B);
        foreach (SSM_CODES[i]) begin
            rx(SSM_CODES[i]);
            bus(0, A_STAT, 0);
            chk(rd[21:8], {6'h20, SSM_CODES[i]});
        end
        send <= 0;
        sec(h);
        {crc, mfe} <= 2'h3;
        repeat (2) @(posedge clk);
        {crc, bpv, slip} <= 3'h3;
        @(posedge clk);
        {mfe, bpv, slip} <= 3'h0;
        sec(rd);
        chk(rd, {h[15:0], 6'h00, h[9:8] + 2'h1, 8'h7A});
        bus(0, A_HIST1, 0);
        chk(rd[15:0], h[31:16]);
        final_report();
    end
endmodule : prdl_bench
